// ==== rtl/vsl_regs.vh ====
// Purpose: Shared constants for the setpoint start-up loader
// Assumes: 100 MHz ref_clk, APB register access
// Notes:   Setpoints in 10 mV units; times in ms
`ifndef VSL_REGS_VH
`define VSL_REGS_VH
// Register byte offsets
`define VSL_CTRL_OFF        12'h000
`define VSL_STATUS_OFF      12'h004
`define VSL_VOUT_CMD_OFF    12'h008
`define VSL_DELAY_CFG_OFF   12'h00c
`define VSL_VOUT_OUT_OFF    12'h010
`define VSL_CEIL_OUT_OFF    12'h014
`define VSL_ID_OFF          12'h018
// Control field positions
`define VSL_CTRL_RESTORE    0
`define VSL_CTRL_SHARE      1
`define VSL_CTRL_AUTOCOMP   2
`define VSL_CTRL_LOWPWR     3
`define VSL_CTRL_NVM_VALID  4
// Reset values
`define VSL_VOUT_DEFAULT    10'h03c
`define VSL_ID_VALUE        32'h5a5a_0001
// Setpoint limits, 10 mV units
`define VSL_VOUT_MIN        10'h03c
`define VSL_OUTPUT_CEILING        10'h1f4
// Timing in ms and clocks
`define VSL_CLK_MHZ         100
`define VSL_MS_CYCLES       (`VSL_CLK_MHZ * 1000)
`define VSL_NVM_MS          6'd5
`define VSL_MIN_DLY_A_MS    6'd5
`define VSL_MIN_DLY_B_MS    6'd10
`define VSL_MIN_DLY_C_MS    6'd15
// Four-state pin codes
`define VSL_PIN_LOW         2'h0
`define VSL_PIN_OPEN        2'h1
`define VSL_PIN_HIGH        2'h2
`define VSL_PIN_RES         2'h3
`endif

// ==== rtl/vsl_ms_tick.v ====
// Purpose: Millisecond enable pulse from ref_clk
// Assumes: Cycles per ms given by parameter
// Notes:   Restarts from zero while clear is high
`timescale 1ns/100ps
`default_nettype none
module vsl_ms_tick #(
    parameter [31:0] CYCLES = 32'd100000
) (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        clear,
    output reg         tick
);
    reg [31:0] cnt_reg;

    // Free divider; clear realigns to the start of a step
    always @(posedge ref_clk) begin
        if (reset || clear) begin
            cnt_reg <= 32'h0000_0000;
            tick    <= 1'b0;
        end else if (cnt_reg == CYCLES - 32'd1) begin
            cnt_reg <= 32'h0000_0000;
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'd1;
            tick    <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/vsl_decode.v ====
// Purpose: Setpoint decode from the two multi-mode pins
// Assumes: Pin modes and resistor indexes already synchronised
// Notes:   Pure combinational; result in 10 mV units
`timescale 1ns/100ps
`default_nettype none
`include "vsl_regs.vh"
module vsl_decode (
    input  wire [1:0]  fine_mode,
    input  wire [1:0]  coarse_mode,
    input  wire [4:0]  fine_index,
    input  wire [4:0]  coarse_index,
    output reg  [9:0]  setpoint,
    output reg         valid
);
    reg [9:0] strap_tab;
    reg [9:0] single_tab;

    // Nine-entry strap table, coarse row then fine column
    always @* begin
        case ({coarse_mode, fine_mode})
            4'h0: strap_tab = 10'd60;
            4'h1: strap_tab = 10'd80;
            4'h2: strap_tab = 10'd100;
            4'h4: strap_tab = 10'd120;
            4'h5: strap_tab = 10'd150;
            4'h6: strap_tab = 10'd180;
            4'h8: strap_tab = 10'd250;
            4'h9: strap_tab = 10'd330;
            4'ha: strap_tab = 10'd500;
            default: strap_tab = 10'd0;
        endcase
    end

    // Single-resistor table; codes 25..30 are the wide resistors
    always @* begin
        if (coarse_index <= 5'd14)
            single_tab = 10'd60 + {5'h00, coarse_index} * 10'd5;
        else if (coarse_index <= 5'd24)
            single_tab = 10'd130 + ({5'h00, coarse_index} - 10'd14) * 10'd10;
        else begin
            case (coarse_index)
                5'd25:   single_tab = 10'd250;
                5'd26:   single_tab = 10'd300;
                5'd27:   single_tab = 10'd330;
                5'd28:   single_tab = 10'd400;
                5'd29:   single_tab = 10'd500;
                5'd30:   single_tab = 10'd550;
                default: single_tab = 10'd0;
            endcase
        end
    end

    // Mode select; unmatched resistor yields invalid
    always @* begin
        setpoint = 10'd0;
        valid    = 1'b0;
        if (coarse_mode == `VSL_PIN_RES && fine_mode == `VSL_PIN_LOW) begin
            setpoint = single_tab;
            valid    = (coarse_index <= 5'd30);
        end else if (coarse_mode == `VSL_PIN_RES && fine_mode == `VSL_PIN_RES) begin
            setpoint = {5'h00, fine_index} + {5'h00, coarse_index} * 10'd25;
            valid    = (fine_index <= 5'd24) && (coarse_index <= 5'd24)
                       && (setpoint >= `VSL_VOUT_MIN)
                       && (setpoint <= `VSL_OUTPUT_CEILING);
        end else if (coarse_mode != `VSL_PIN_RES && fine_mode != `VSL_PIN_RES) begin
            setpoint = strap_tab;
            valid    = (strap_tab != 10'd0);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/vsl_loader.v ====
// Purpose: Start-up sequencer and output setpoint selector
// Assumes: Pin and resistor measurements arrive as async levels
// Notes:   APB slave holds setpoint command, delay and mode bits
`timescale 1ns/100ps
`default_nettype none
`include "vsl_regs.vh"
module vsl_loader #(
    parameter [31:0] MS_CYCLES = `VSL_MS_CYCLES
) (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        enable_pin,
    input  wire [1:0]  setpoint_fine_pin,
    input  wire [1:0]  setpoint_coarse_pin,
    input  wire [4:0]  fine_index,
    input  wire [4:0]  coarse_index,
    input  wire [1:0]  soft_start_pin,
    output reg  [9:0]  vout_target,
    output reg  [10:0] output_ceiling,
    output reg  [4:0]  ramp_ms,
    output reg         ramp_start,
    output reg         ramping,
    output wire        device_ready
);
    // Sequencer states
    localparam [2:0] ST_POWER = 3'd0;
    localparam [2:0] ST_NVM   = 3'd1;
    localparam [2:0] ST_PINS  = 3'd2;
    localparam [2:0] ST_READY = 3'd3;
    localparam [2:0] ST_DELAY = 3'd4;
    localparam [2:0] ST_RAMP  = 3'd5;

    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg [5:0]  ms_cnt_reg;
    reg [4:0]  ctrl_reg;
    reg [9:0]  vout_cmd_reg;
    reg [5:0]  delay_cfg_reg;
    reg        restore_reg;
    reg [15:0] pin_meta_reg;
    reg [15:0] pin_sync_reg;
    reg [1:0]  en_sync_reg;
    reg [5:0]  min_dly;
    reg [5:0]  eff_dly;
    wire       ms_tick;
    wire       step_clear;
    wire [9:0] dec_setpoint;
    wire       dec_valid;
    wire       wr_acc;
    wire       addr_ok;
    wire       en_s;
    wire [1:0] ss_mode_s;
    wire [1:0] fine_mode_s;
    wire [1:0] coarse_mode_s;
    wire [4:0] fine_idx_s;
    wire [4:0] coarse_idx_s;
    wire       nvm_done;
    wire       delay_done;
    wire       pins_load;
    wire       cmd_legal;

    // Pins cross two flops; only the second stage is read.
    // Each pin keeps its own index; the pin step samples them long after
    // they settle, so a multi-bit skew in the flops cannot be loaded.
    always @(posedge ref_clk) begin
        if (reset) begin
            pin_meta_reg <= 16'h0000;
            pin_sync_reg <= 16'h0000;
            en_sync_reg  <= 2'h0;
        end else begin
            pin_meta_reg <= {soft_start_pin, setpoint_fine_pin, setpoint_coarse_pin,
                             fine_index, coarse_index};
            pin_sync_reg <= pin_meta_reg;
            en_sync_reg  <= {en_sync_reg[0], enable_pin};
        end
    end
    assign en_s = en_sync_reg[1];

    // Synchronised pin fields
    assign ss_mode_s     = pin_sync_reg[15:14];
    assign fine_mode_s   = pin_sync_reg[13:12];
    assign coarse_mode_s = pin_sync_reg[11:10];
    assign fine_idx_s    = pin_sync_reg[9:5];
    assign coarse_idx_s  = pin_sync_reg[4:0];

    vsl_ms_tick #(
        .CYCLES (MS_CYCLES)
    ) u_tick (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clear   (step_clear),
        .tick    (ms_tick)
    );

    vsl_decode u_dec (
        .fine_mode    (fine_mode_s),
        .coarse_mode  (coarse_mode_s),
        .fine_index   (fine_idx_s),
        .coarse_index (coarse_idx_s),
        .setpoint     (dec_setpoint),
        .valid        (dec_valid)
    );

    // Mode-dependent minimum delay; mode bits come from config
    always @* begin
        if (ctrl_reg[`VSL_CTRL_SHARE] && (ctrl_reg[`VSL_CTRL_AUTOCOMP] ||
            ctrl_reg[`VSL_CTRL_LOWPWR]))
            min_dly = `VSL_MIN_DLY_C_MS;
        else if (ctrl_reg[`VSL_CTRL_LOWPWR])
            min_dly = `VSL_MIN_DLY_B_MS;
        else
            min_dly = `VSL_MIN_DLY_A_MS;
        // Short configured delays are lifted to the minimum
        if (delay_cfg_reg < min_dly)
            eff_dly = min_dly;
        else
            eff_dly = delay_cfg_reg;
    end

    // Step completion strobes; the NVM and delay strobes fire on the last millisecond tick
    assign nvm_done   = ms_tick && (ms_cnt_reg == `VSL_NVM_MS - 6'd1);
    assign delay_done = ms_tick && (ms_cnt_reg == eff_dly - 6'd1);
    assign pins_load  = (state_reg == ST_PINS);
    // Out-of-range host setpoints are stored but never adopted
    assign cmd_legal  = wr_acc && (paddr == `VSL_VOUT_CMD_OFF) &&
                        (pwdata[9:0] >= `VSL_VOUT_MIN) &&
                        (pwdata[9:0] <= `VSL_OUTPUT_CEILING);

    // Sequencer; each step waits for the previous to complete
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_POWER: state_next = ST_NVM;
            ST_NVM:   if (nvm_done)
                          state_next = ST_PINS;
            ST_PINS:  state_next = ST_READY;
            ST_READY: if (en_s)
                          state_next = ST_DELAY;
            ST_DELAY: if (!en_s)
                          state_next = ST_READY;
                      else if (delay_done)
                          state_next = ST_RAMP;
            ST_RAMP:  if (!en_s)
                          state_next = ST_READY;
            default:  state_next = ST_POWER;
        endcase
        if (restore_reg)
            state_next = ST_NVM;
    end

    assign step_clear = (state_next != state_reg);

    // State and millisecond step counter
    always @(posedge ref_clk) begin
        if (reset) begin
            state_reg  <= ST_POWER;
            ms_cnt_reg <= 6'h00;
        end else begin
            state_reg <= state_next;
            // Counter restarts on every step change
            if (step_clear)
                ms_cnt_reg <= 6'h00;
            else if (ms_tick)
                ms_cnt_reg <= ms_cnt_reg + 6'h01;
        end
    end

    // Setpoint and ceiling; an unmatched pin code keeps the old target
    always @(posedge ref_clk) begin
        if (reset) begin
            vout_target    <= `VSL_VOUT_DEFAULT;
            output_ceiling <= 11'h042;
        end else begin
            if (pins_load && dec_valid) begin
                vout_target    <= dec_setpoint;
                output_ceiling <= {1'b0, dec_setpoint} +
                                  {1'b0, dec_setpoint} / 11'd10;
            end
            // Ceiling stays pin-derived; only the target follows the host
            if (cmd_legal)
                vout_target <= pwdata[9:0];
        end
    end

    // Soft-start ramp time, latched with the other pin settings
    always @(posedge ref_clk) begin
        if (reset)
            ramp_ms <= 5'h02;
        else if (pins_load) begin
            case (ss_mode_s)
                `VSL_PIN_LOW:  ramp_ms <= 5'd2;
                `VSL_PIN_OPEN: ramp_ms <= 5'd5;
                default:       ramp_ms <= 5'd10;
            endcase
        end
    end

    // One-cycle ramp start and the ramping level
    always @(posedge ref_clk) begin
        if (reset) begin
            ramp_start <= 1'b0;
            ramping    <= 1'b0;
        end else begin
            ramp_start <= (state_reg == ST_DELAY) && (state_next == ST_RAMP);
            ramping    <= (state_next == ST_RAMP);
        end
    end

    // Bus writes only once loading is done
    assign device_ready = (state_reg >= ST_READY) && (state_reg <= ST_RAMP);
    assign wr_acc = psel && penable && pwrite && device_ready;
    assign addr_ok = (paddr == `VSL_CTRL_OFF) || (paddr == `VSL_STATUS_OFF) ||
                     (paddr == `VSL_VOUT_CMD_OFF) || (paddr == `VSL_DELAY_CFG_OFF) ||
                     (paddr == `VSL_VOUT_OUT_OFF) || (paddr == `VSL_CEIL_OUT_OFF) ||
                     (paddr == `VSL_ID_OFF);
    assign pready  = 1'b1;
    // Error on unmapped address or write while busy loading
    assign pslverr = psel && penable && (!addr_ok || (pwrite && !device_ready));

    // Config registers; restore pulse self-clears
    always @(posedge ref_clk) begin
        if (reset) begin
            ctrl_reg      <= 5'h00;
            vout_cmd_reg  <= `VSL_VOUT_DEFAULT;
            delay_cfg_reg <= 6'h00;
            restore_reg   <= 1'b0;
        end else begin
            restore_reg <= 1'b0;
            if (wr_acc) begin
                case (paddr)
                    `VSL_CTRL_OFF: begin
                        ctrl_reg    <= {1'b0, pwdata[3:1], 1'b0};
                        restore_reg <= pwdata[`VSL_CTRL_RESTORE];
                    end
                    `VSL_VOUT_CMD_OFF:  vout_cmd_reg  <= pwdata[9:0];
                    `VSL_DELAY_CFG_OFF: delay_cfg_reg <= pwdata[5:0];
                    default: ;
                endcase
            end
        end
    end

    // Read mux, registered data out
    always @(posedge ref_clk) begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) begin
            case (paddr)
                `VSL_CTRL_OFF:      prdata <= {27'h0, ctrl_reg};
                `VSL_STATUS_OFF:    prdata <= {24'h0, ramping, device_ready,
                                               3'h0, state_reg};
                `VSL_VOUT_CMD_OFF:  prdata <= {22'h0, vout_cmd_reg};
                `VSL_DELAY_CFG_OFF: prdata <= {26'h0, delay_cfg_reg};
                `VSL_VOUT_OUT_OFF:  prdata <= {22'h0, vout_target};
                `VSL_CEIL_OUT_OFF:  prdata <= {21'h0, output_ceiling};
                `VSL_ID_OFF:        prdata <= `VSL_ID_VALUE; // Arbitrary value
                default:            prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== testbench/vsl_loader_checker.sv ====
// Purpose: Port-level assertions for the setpoint loader
// Assumes: One clock, synchronous active-high reset
// Notes:   Long waits are counted in helper logic, not unrolled
`timescale 1ns/100ps
`default_nettype none
module vsl_loader_checker #(
    parameter [31:0] MS_CYCLES = 32'd100000
) (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        enable_pin,
    input wire logic [9:0]  vout_target,
    input wire logic [10:0] output_ceiling,
    input wire logic        ramp_start,
    input wire logic        ramping,
    input wire logic        device_ready
);
    localparam int NVM_CYC = 5 * MS_CYCLES;
    logic [31:0] low_cnt, en_cnt;
    logic [9:0]  cmd_val;
    logic        wr, cmd_wr, cmd_ok;
    // Decoded bus events
    assign wr = psel && penable && pwrite;
    assign cmd_wr = wr && paddr == 12'h008;
    assign cmd_ok = pwdata[9:0] >= 10'h03c && pwdata[9:0] <= 10'h1f4;
    // Run lengths; enable is async, so sync delay only adds cycles
    always_ff @(posedge ref_clk) begin
        low_cnt <= (reset || device_ready) ? 32'h0 : low_cnt + 32'h1;
        en_cnt <= (reset || !enable_pin) ? 32'h0 : en_cnt + 32'h1;
        if (cmd_wr)
            cmd_val <= pwdata[9:0];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    AST_NVM_TIME: assert property ($rose(device_ready) |-> low_cnt >= NVM_CYC)
        else $error("ready came before the memory check time");
    AST_BUSY_ERR: assert property (wr && !device_ready |-> pslverr)
        else $error("write while loading was not refused");
    AST_BUSY_HOLD: assert property (cmd_wr && !device_ready |=> $stable(vout_target))
        else $error("setpoint moved on a write while loading");
    AST_RAMP_WAIT: assert property (ramp_start |-> en_cnt >= NVM_CYC)
        else $error("ramp started before the minimum delay");
    AST_RAMP_PULSE: assert property (ramp_start |=> !ramp_start && ramping)
        else $error("ramp start not a single pulse into ramping");
    AST_RAMP_STOP: assert property (ramping && !enable_pin |-> ##[1:4] !ramping)
        else $error("ramping kept after enable dropped");
    AST_CEIL: assert property ($changed(output_ceiling) |->
        output_ceiling == {1'b0, vout_target} + {1'b0, vout_target} / 11'd10)
        else $error("ceiling not ten percent above setpoint");
    AST_CMD_TAKE: assert property (cmd_wr && device_ready && cmd_ok |->
        ##[1:3] vout_target == cmd_val)
        else $error("legal setpoint command not adopted");
    AST_CMD_RANGE: assert property (cmd_wr && device_ready && !cmd_ok |=>
        $stable(vout_target) [*3])
        else $error("out of range setpoint command adopted");
endmodule
bind vsl_loader vsl_loader_checker #(.MS_CYCLES(MS_CYCLES)) u_vsl_loader_checker (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .enable_pin(enable_pin),
    .vout_target(vout_target), .output_ceiling(output_ceiling), .ramp_start(ramp_start),
    .ramping(ramping), .device_ready(device_ready));
`default_nettype wire

// ==== testbench/vsl_strap_model.sv ====
// Purpose: Strap pins, setpoint resistors and enable source
// Assumes: Bench picks pin modes and one resistor index
// Notes:   Bench drives one index onto both resistors
`timescale 1ns/100ps
`default_nettype none
module vsl_strap_model (
    input  wire logic [1:0] fm,
    input  wire logic [1:0] cm,
    input  wire logic [1:0] ss,
    input  wire logic [4:0] idx,
    input  wire logic       en_req,
    output logic      [1:0] setpoint_fine_pin,
    output logic      [1:0] setpoint_coarse_pin,
    output logic      [1:0] soft_start_pin,
    output logic      [4:0] fine_index,
    output logic      [4:0] coarse_index,
    output logic            enable_pin
);
    // Level or resistor on each multi-mode pin; low fine pin is ground
    assign setpoint_fine_pin = fm;
    assign setpoint_coarse_pin = cm;
    assign soft_start_pin = ss;
    // One standard resistor per index, 0 to 24 in two-resistor use
    assign fine_index = idx;
    assign coarse_index = idx;
    // Clock is steady from time zero, so enable may follow at once
    assign enable_pin = en_req;
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the setpoint start-up loader
// Assumes: MS_CYCLES of 10; APB waits on pready
// Notes:   Pins count only after power-up or a restore, so each case reloads
`timescale 1ns/100ps
`default_nettype none
`include "vsl_regs.vh"
module testbench;
    localparam int MS = 10;
    localparam int STRAP [9] = '{60, 80, 100, 120, 150, 180, 250, 330, 500};
    localparam int SINGLE [6] = '{250, 300, 330, 400, 500, 550};
    localparam logic [2:0] MODE [6] = '{3'h0, 3'h5, 3'h6, 3'h3, 3'h2, 3'h0};
    localparam int CFG [6] = '{0, 0, 0, 0, 3, 20};
    localparam int DLY [6] = '{5, 15, 10, 15, 5, 20};
    logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic        en_req, enable_pin, ramp_start, ramping, device_ready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  fm, cm, ss, fpin, cpin, sspin;
    logic [4:0]  idx, fidx, cidx, ramp_ms;
    logic [9:0]  vout_target;
    logic [10:0] output_ceiling;
    int          bad_count, num_checks, cyc, n, e;
    vsl_strap_model u_vsl_strap_model (.fm(fm), .cm(cm), .ss(ss), .idx(idx), .en_req(en_req),
        .setpoint_fine_pin(fpin), .setpoint_coarse_pin(cpin), .soft_start_pin(sspin),
        .fine_index(fidx), .coarse_index(cidx), .enable_pin(enable_pin));
    vsl_loader #(.MS_CYCLES(32'd10)) u_vsl_loader (.ref_clk(ref_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .enable_pin(enable_pin),
        .setpoint_fine_pin(fpin), .setpoint_coarse_pin(cpin), .fine_index(fidx),
        .coarse_index(cidx), .soft_start_pin(sspin), .vout_target(vout_target),
        .output_ceiling(output_ceiling), .ramp_ms(ramp_ms), .ramp_start(ramp_start),
        .ramping(ramping), .device_ready(device_ready));
    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Hang guard, far above the few thousand cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ev, input logic [31:0] sv);
        num_checks++;
        if (sv !== ev) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, ev, sv);
        end
    endtask
    // One APB transfer; data and error taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // Bounded wait for ramp start or for ready
    task automatic wt(input bit ramp);
        n = 0;
        while ((ramp ? ramp_start : device_ready) !== 1'b1 && n < 600) begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    // New pins, restore with mode bits, then a write while busy
    task automatic load(input logic [1:0] f, c, input logic [4:0] i, input logic [2:0] m);
        {fm, cm, idx} <= {f, c, i};
        apb(1'b1, `VSL_CTRL_OFF, {28'h0, m, 1'b1});
        apb(1'b1, `VSL_VOUT_CMD_OFF, 32'h0c8);
        chk("busy_err", 1, err);
        wt(1'b0);
        chk("load_time", 1, n >= 4 * MS && n <= 10 * MS);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fm, cm, ss, idx} = '0;
        {reset, en_req} = 2'b11;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        // Enable tied high from power-up
        wt(1'b1);
        chk("tied_en", 1, n >= 10 * MS && n < 600);
        chk("first_vout", 60, vout_target);
        en_req <= 1'b0;
        // Every strap pair
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 3; c++) begin
                load(2'(c), 2'(r), 5'h0, 3'h0);
                e = STRAP[r * 3 + c];
                chk("strap_vout", e, vout_target);
                chk("strap_ceil", e + e / 10, output_ceiling);
            end
        end
        // Single resistor codes, then an unmatched one
        for (int i = 0; i <= 30; i += 3) begin
            load(2'h0, 2'h3, 5'(i), 3'h0);
            e = (i < 15) ? 60 + 5 * i : (i < 25) ? 130 + 10 * (i - 14) : SINGLE[i - 25];
            chk("single_vout", e, vout_target);
        end
        load(2'h0, 2'h3, 5'h1f, 3'h0);
        chk("bad_res", 550, vout_target);
        for (int i = 3; i <= 19; i += 8) begin
            load(2'h3, 2'h3, 5'(i), 3'h0);
            chk("two_vout", 26 * i, vout_target);
        end
        // Bus setpoint at both limits, each followed by a step outside
        apb(1'b1, `VSL_VOUT_CMD_OFF, 32'h1f4);
        chk("cmd_err", 0, err);
        apb(1'b1, `VSL_VOUT_CMD_OFF, 32'h1f5);
        apb(1'b0, `VSL_VOUT_OUT_OFF, 32'h0);
        chk("cmd_max", 32'h1f4, rd);
        apb(1'b1, `VSL_VOUT_CMD_OFF, 32'h03c);
        apb(1'b1, `VSL_VOUT_CMD_OFF, 32'h03b);
        apb(1'b0, `VSL_VOUT_OUT_OFF, 32'h0);
        chk("cmd_min", 32'h03c, rd);
        // Pre-ramp delay per mode and soft-start ramp per pin
        for (int k = 0; k < 6; k++) begin
            ss <= 2'(k % 4);
            load(2'h0, 2'h0, 5'h0, MODE[k]);
            apb(1'b1, `VSL_DELAY_CFG_OFF, CFG[k]);
            en_req <= 1'b1;
            wt(1'b1);
            chk("pre_ramp", 1, n >= DLY[k] * MS && n <= DLY[k] * MS + 6);
            chk("ramp_ms", (k % 4 == 0) ? 2 : (k % 4 == 1) ? 5 : 10, ramp_ms);
            @(posedge ref_clk);
            chk("ramping", 1, ramping);
            en_req <= 1'b0;
            repeat (6) @(posedge ref_clk);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
